/* File: common/flash_host_pkg.sv */
package flash_host_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int SECT_W = 5;
  // clock rate and bus timing
  localparam int CLK_NS = 100;
  localparam int T_ACC_NS = 120;   // access time, chip select or address to data
  localparam int T_WP_NS = 50;     // least write strobe low time
  localparam int T_RP_NS = 500;    // least reset pulse
  localparam int T_RH_NS = 50;     // reset high to first access
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RP_CYC = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RH_CYC = 4'((T_RH_NS + CLK_NS - 1) / CLK_NS);
  // protect and unprotect address pattern bits
  localparam int A0_POS = 0;
  localparam int A1_POS = 1;
  localparam int A6_POS = 6;
  localparam int SECT_LSB = 16;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // user request kinds
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RESET = 3'h2,
    OP_PROTECT = 3'h3,
    OP_UNPROTECT = 3'h4
  } op_t;

  // gray coded sequencer, usual path idle->setup->strobe->hold->idle
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b010,
    ST_RESET = 3'b110,
    ST_RECOVER = 3'b111
  } state_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic vid_en;    // reset pin at elevated voltage level
  } strobe_t;

  typedef struct packed {
    state_t st;
    logic [3:0] cnt;
    req_t req;
    strobe_t pins;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic busy;
    logic was_standby;
  } host_state_t;
endpackage

/* File: logic/flash_host.sv */
`timescale 1ns/1ps
// What this block does
// - read: select and output enable low, write high
// - write: select and write low, output high
// - wait full select access time after standby
// - protect: strobes, elevated reset, A6 low A1 high A0 low
// - unprotect: same, but A6 high
module flash_host (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // user request
  input wire logic REQ_VALID,
  input flash_host_pkg::req_t REQ,
  output logic REQ_READY,
  output logic DONE,
  output logic [flash_host_pkg::DATA_W-1:0] RDATA,
  output logic BUSY,
  // flash pins
  output flash_host_pkg::strobe_t PINS,
  output logic [flash_host_pkg::ADDR_W-1:0] ADDRESS_BUS,
  input wire logic [flash_host_pkg::DATA_W-1:0] DATA_BUS_IN,
  output logic [flash_host_pkg::DATA_W-1:0] DATA_BUS_OUT,
  output logic DATA_BUS_OE,
  input wire logic READY_BUSY_N
);
  import flash_host_pkg::*;

  host_state_t s_r;
  host_state_t s_nxt;
  localparam strobe_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, vid_en: 1'b0};

  // next state of the whole sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.busy = ~READY_BUSY_N;
    case (s_r.st)
      ST_IDLE: begin
        if (REQ_VALID) begin
          s_nxt.req = REQ;
          s_nxt.addr = REQ.addr;    // sector select bits pass through untouched
          s_nxt.cnt = CNT_ZERO;
          if (REQ.op == OP_RESET) begin
            s_nxt.pins = PINS_IDLE;
            s_nxt.pins.reset_n = 1'b0;
            s_nxt.doe = 1'b0;
            s_nxt.st = ST_RESET;
          end else begin
            // address first, data drives for every op but read, select low, strobes still high
            s_nxt.pins = PINS_IDLE;
            s_nxt.pins.ce_n = 1'b0;
            if (REQ.op == OP_PROTECT || REQ.op == OP_UNPROTECT) begin
              s_nxt.pins.vid_en = 1'b1;
              s_nxt.addr[A6_POS] = (REQ.op == OP_UNPROTECT);
              s_nxt.addr[A1_POS] = 1'b1;
              s_nxt.addr[A0_POS] = 1'b0;
            end
            s_nxt.doe = (REQ.op != OP_READ);
            s_nxt.dout = REQ.data;
            s_nxt.st = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (s_r.req.op == OP_READ) begin
          s_nxt.pins.oe_n = 1'b0;
          s_nxt.pins.we_n = 1'b1;
          s_nxt.doe = 1'b0;
          // coming out of standby needs full select access time
          s_nxt.cnt = ACC_CYC;
        end else begin
          s_nxt.pins.we_n = 1'b0;
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.cnt = WP_CYC;
        end
        s_nxt.st = ST_STROBE;
      end
      ST_STROBE: begin
        if (s_r.cnt > CNT_ONE) begin
          s_nxt.cnt = s_r.cnt - CNT_ONE;
        end else begin
          if (s_r.req.op == OP_READ) begin
            s_nxt.rdata = DATA_BUS_IN;
          end
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.pins.we_n = 1'b1;    // data taken on this rising edge
          s_nxt.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // release select: device finishes any embedded work on its own
        s_nxt.pins = PINS_IDLE;
        s_nxt.doe = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st = ST_IDLE;
      end
      ST_RESET: begin
        if (s_r.cnt < RP_CYC) begin
          s_nxt.cnt = s_r.cnt + CNT_ONE;
        end else begin
          s_nxt.pins.reset_n = 1'b1;    // device back in read array
          s_nxt.cnt = CNT_ZERO;
          s_nxt.st = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // wait reset recovery and for ready busy to rise
        if (s_r.cnt < RH_CYC) begin
          s_nxt.cnt = s_r.cnt + CNT_ONE;
        end else if (READY_BUSY_N) begin
          s_nxt.done = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // register the state, reset idles all pins with the device reset pin high
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_r.st <= ST_IDLE;
      s_r.cnt <= CNT_ZERO;
      s_r.req <= '0;
      s_r.pins <= PINS_IDLE;
      s_r.addr <= '0;
      s_r.dout <= '0;
      s_r.doe <= 1'b0;
      s_r.rdata <= '0;
      s_r.done <= 1'b0;
      s_r.busy <= 1'b0;
      s_r.was_standby <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops, REQ_READY decoded from the state
  assign PINS = s_r.pins;
  assign ADDRESS_BUS = s_r.addr;
  assign DATA_BUS_OUT = s_r.dout;
  assign DATA_BUS_OE = s_r.doe;
  assign RDATA = s_r.rdata;
  assign DONE = s_r.done;
  assign BUSY = s_r.busy;
  assign REQ_READY = (s_r.st == ST_IDLE);

  // never drive data while output enable low
  a_no_contention: assert property (@(posedge CLK) disable iff (!NRST)
    !(s_r.doe && !s_r.pins.oe_n)) else $error("data driven during read");
  a_write_levels: assert property (@(posedge CLK) disable iff (!NRST)
    !s_r.pins.we_n |-> !s_r.pins.ce_n && s_r.pins.oe_n && s_r.doe) else $error("bad write levels");
  a_read_levels: assert property (@(posedge CLK) disable iff (!NRST)
    !s_r.pins.oe_n |-> !s_r.pins.ce_n && s_r.pins.we_n) else $error("bad read levels");
  sequence read_start_s;
    $fell(s_r.pins.oe_n);
  endsequence
  a_read_access: assert property (@(posedge CLK) disable iff (!NRST)
    read_start_s |-> !s_r.pins.oe_n [*2]) else $error("read strobe too short");
  a_prot_vid: assert property (@(posedge CLK) disable iff (!NRST)
    s_r.pins.vid_en && !s_r.pins.we_n |-> s_r.addr[A1_POS] && !s_r.addr[A0_POS]) else $error("bad protect pattern");
  a_unprot_a6: assert property (@(posedge CLK) disable iff (!NRST)
    s_r.pins.vid_en && s_r.req.op == OP_UNPROTECT |-> s_r.addr[A6_POS]) else $error("unprotect A6 low");
  a_reset_float: assert property (@(posedge CLK) disable iff (!NRST)
    !s_r.pins.reset_n |-> !s_r.doe && s_r.pins.ce_n) else $error("active during reset");
  sequence reset_start_s;
    $fell(s_r.pins.reset_n);
  endsequence
  a_reset_width: assert property (@(posedge CLK) disable iff (!NRST)
    reset_start_s |-> !s_r.pins.reset_n [*5]) else $error("reset pulse too short");
  a_addr_stable: assert property (@(posedge CLK) disable iff (!NRST)
    !s_r.pins.we_n |-> $stable(s_r.addr) && $stable(s_r.dout)) else $error("bus moved");
endmodule // flash_host

/* File: sim/flash_dev_model.sv */
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A,  // arbitrary code
  parameter logic [7:0] DEV_ID = 8'hC3,  // arbitrary code
  parameter int BUSY_NS = 1000
) (
  // host strobes and buses
  input flash_host_pkg::strobe_t pins,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] din,
  // device answers
  output logic [7:0] dout,
  output logic dout_en,
  output logic ready_busy_n
);
  import flash_host_pkg::*;
  logic [7:0] mem [256];
  logic [23:0] hist;
  logic autosel_r, bypass_r, prog_r, busy_r;
  logic [7:0] pa, pd;
  // power-up in read array, all bytes erased
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {hist, autosel_r, bypass_r, prog_r, busy_r} = '0;
  end
  // drive data only in a clean read cycle
  assign dout_en = !pins.ce_n && !pins.oe_n && pins.we_n && pins.reset_n;
  assign dout = busy_r ? {~pd[7], 7'h00} : autosel_r ? (addr[0] ? DEV_ID : MAKER_ID) : mem[addr[7:0]];
  assign ready_busy_n = !busy_r;
  // command latches taken on the closing write strobe
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.reset_n && !pins.vid_en && !busy_r) begin
      if (prog_r) begin
        pa = addr[7:0];
        pd = din;
        prog_r = 0;
        busy_r = 1;
      end else if (din == 8'hF0) begin
        autosel_r = 0;
        hist = '0;
      end else begin
        hist = {hist[15:0], din};
        autosel_r |= hist == 24'hAA_5590;
        bypass_r |= hist == 24'hAA_5520;
        prog_r = hist == 24'hAA_55A0 || (bypass_r && din == 8'hA0);
      end
    end
  end
  // embedded timer ignores deselect, only reset cuts it
  always begin
    @(posedge busy_r);
    fork
      #(BUSY_NS);
      @(negedge pins.reset_n);
    join_any
    disable fork;
    if (pins.reset_n) mem[pa] = pd;
    else @(posedge pins.reset_n);
    busy_r = 0;
  end
  // reset returns to read array
  always @(negedge pins.reset_n) begin
    {hist, autosel_r, bypass_r, prog_r} = '0;
  end
endmodule  // flash_dev_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import flash_host_pkg::*;
  localparam op_t W = OP_WRITE;
  localparam op_t R = OP_READ;
  logic CLK, NRST, REQ_VALID, REQ_READY, DONE, BUSY, DATA_BUS_OE, READY_BUSY_N, dev_en;
  req_t REQ;
  strobe_t PINS;
  logic [ADDR_W-1:0] ADDRESS_BUS;
  logic [7:0] RDATA, DATA_BUS_OUT, DATA_BUS_IN, dev_d;
  int n_fail, cmp_count, cyc;
  // op, address, write data or expected read byte
  req_t rows [$] = '{'{R, 21'h10, 8'hFF}, '{W, 21'h555, 8'hAA}, '{W, 21'h2AA, 8'h55}, '{W, 21'h555, 8'hA0},
    '{W, 21'h10, 8'h3C}, '{R, 21'h10, 8'h80}, '{R, 21'h10, 8'h3C}, '{W, 21'h555, 8'hAA},
    '{W, 21'h2AA, 8'h55}, '{W, 21'h555, 8'h90}, '{R, 21'h0, 8'h5A}, '{R, 21'h1, 8'hC3},
    '{W, 21'h0, 8'hF0}, '{R, 21'h10, 8'h3C}, '{OP_PROTECT, 21'h3_0000, 8'h0}, '{OP_UNPROTECT, 21'h3_0000, 8'h0},
    '{W, 21'h555, 8'hAA}, '{W, 21'h2AA, 8'h55}, '{W, 21'h555, 8'h20}, '{W, 21'h0, 8'hA0},
    '{W, 21'h30, 8'h55}, '{R, 21'h30, 8'h80}, '{R, 21'h30, 8'h55}, '{W, 21'h0, 8'hA0},
    '{W, 21'h20, 8'h77}, '{OP_RESET, 21'h0, 8'h0}, '{R, 21'h20, 8'hFF}, '{W, 21'h0, 8'hA0},
    '{W, 21'h20, 8'h11}, '{R, 21'h20, 8'hFF}};
  // shared data lines, released lines toggle
  assign DATA_BUS_IN = DATA_BUS_OE ? DATA_BUS_OUT : dev_en ? dev_d : {8{CLK}} ^ 8'hA5;
  flash_host flash_host_i (.CLK(CLK), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
    .DONE(DONE), .RDATA(RDATA), .BUSY(BUSY), .PINS(PINS), .ADDRESS_BUS(ADDRESS_BUS), .DATA_BUS_IN(DATA_BUS_IN),
    .DATA_BUS_OUT(DATA_BUS_OUT), .DATA_BUS_OE(DATA_BUS_OE), .READY_BUSY_N(READY_BUSY_N));
  flash_dev_model flash_dev_model_i (.pins(PINS), .addr(ADDRESS_BUS), .din(DATA_BUS_IN), .dout(dev_d),
    .dout_en(dev_en), .ready_busy_n(READY_BUSY_N));
  // clock
  initial begin
    CLK = 0;
    forever #50 CLK = ~CLK;
  end
  // hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task chk(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one request, wait for its end, check read byte
  task run(req_t r);
    @(negedge CLK);
    REQ_VALID = 1;
    REQ = r;
    while (REQ_READY !== 1'b1) @(negedge CLK);
    @(negedge CLK);
    REQ_VALID = 0;
    for (int k = 0; k < 200 && DONE !== 1'b1; k++) @(negedge CLK);
    chk("done", {7'h0, DONE}, 8'h01);
    if (r.op == R) chk("rdata", RDATA, r.data);
    if (r.op == R && r.data == 8'h80) chk("busy", {7'h0, BUSY}, 8'h01);
  endtask
  // main sequence
  initial begin
    NRST = 0;
    REQ_VALID = 0;
    REQ = '0;
    repeat (12) @(negedge CLK);
    NRST = 1;
    foreach (rows[i]) run(rows[i]);
    // reset in the middle of a read
    REQ_VALID = 1;
    REQ = '{R, 21'h30, 8'h55};
    @(negedge CLK);
    REQ_VALID = 0;
    @(negedge CLK);
    NRST = 0;
    @(negedge CLK);
    chk("pins", {3'h0, PINS}, 8'h1E);
    chk("oe", {6'h0, DATA_BUS_OE, REQ_READY}, 8'h01);
    NRST = 1;
    run(REQ);
    tally_and_finish();
  end
endmodule  // tb
